// ==== stcp_pkg.sv ====
// Purpose: shared constants and carrier types of the 10-bit standard timer
// Assumes: byte-wide register port, 100 MHz clk_in
// Notes: register offsets are indices on a 3-bit address
package stcp_pkg;
  localparam int CNT_W = 10;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_CMPA_HI = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 3'h6;

  // control0 fields
  localparam int PAUSE_BIT = 7;
  localparam int CKSEL_LSB = 4;
  localparam int ON_BIT = 3;
  localparam int CMPP_LSB = 0;
  // mode_control_reg fields
  localparam int OPMODE_LSB = 6;
  localparam int PINACT_LSB = 4;
  localparam int INIT_BIT = 3;
  localparam int INV_BIT = 2;
  localparam int SWAP_BIT = 1;
  localparam int CLRSRC_BIT = 0;
  // flag register fields, write one to clear
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;

  // reset values
  localparam logic [DATA_W-1:0] CTRL0_RST = 8'h00;
  localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CMPA_RST = 10'h000;

  // op_mode_sel codes
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  // pin_action_sel codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] PWM_FORCE_OFF = 2'h0;
  localparam logic [1:0] PWM_FORCE_ON = 2'h1;
  localparam logic [1:0] PWM_RUN = 2'h2;

  // comparator P looks at counter bits 9..7, so one step is 128 counts
  localparam int P_SHIFT = 7;
  localparam logic [CNT_W:0] P_FULL = 11'h400;

  // timer clock source codes and prescaler masks
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_H16 = 3'h2;
  localparam logic [2:0] CK_H64 = 3'h3;
  localparam logic [2:0] CK_TB0 = 3'h4;
  localparam logic [2:0] CK_TB1 = 3'h5;
  localparam logic [2:0] CK_PIN_RISE = 3'h6;
  localparam logic [2:0] CK_PIN_FALL = 3'h7;
  localparam logic [7:0] MASK_DIV4 = 8'h03;
  localparam logic [7:0] MASK_DIV16 = 8'h0F;
  localparam logic [7:0] MASK_DIV64 = 8'h3F;
  localparam logic [7:0] MASK_DIVTB = 8'hFF;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } stcp_bus_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl0;
    logic [DATA_W-1:0] mode;
    logic [CNT_W-1:0] cmpa;
    logic [CNT_W-1:0] cnt;
    logic flag_a;
    logic flag_p;
    logic on_prev;
    logic pin_lvl;
    logic pin;
    logic pin_oe;
    logic [DATA_W-1:0] rd_data;
  } stcp_state_t;

  typedef struct packed {
    logic [7:0] div;
    logic sync1;
    logic sync2;
    logic ext_prev;
    logic tick;
  } stcp_pre_state_t;
endpackage : stcp_pkg

// ==== stcp_prescale.sv ====
// Purpose: timer clock enable from internal dividers or the external clock pin
// Assumes: tck_in is asynchronous to clk_in
// Notes: tick_out is a one-cycle enable, never a clock
`timescale 1ns/1ps
module stcp_prescale (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] clk_sel_in,
  input wire logic tck_in,
  output logic tick_out
);
  import stcp_pkg::*;

  stcp_pre_state_t st;
  stcp_pre_state_t next_st;

  function automatic logic div_hit(input logic [7:0] div, input logic [7:0] mask);
    div_hit = (div & mask) == mask;
  endfunction : div_hit

  always_comb begin
    next_st = st;
    next_st.div = st.div + 8'h01;
    // first sync stage feeds only the second
    next_st.sync1 = tck_in;
    next_st.sync2 = st.sync1;
    next_st.ext_prev = st.sync2;
    unique case (clk_sel_in)
      CK_SYS4: next_st.tick = div_hit(st.div, MASK_DIV4);
      CK_SYS: next_st.tick = 1'b1;
      CK_H16: next_st.tick = div_hit(st.div, MASK_DIV16);
      CK_H64: next_st.tick = div_hit(st.div, MASK_DIV64);
      CK_TB0, CK_TB1: next_st.tick = div_hit(st.div, MASK_DIVTB);
      CK_PIN_RISE: next_st.tick = st.sync2 & ~st.ext_prev;
      CK_PIN_FALL: next_st.tick = ~st.sync2 & st.ext_prev;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;
endmodule : stcp_prescale

// ==== stcp_timer.sv ====
// Purpose: 10-bit standard timer with compare-match, timer/counter and PWM modes
// Assumes: byte register port, one clock, timer clock given as an enable
// Notes: single-pulse and capture behaviour are not built; those codes just count
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

// Notes on behaviour
// - counter readable as low and high bytes
// - comparator A ten bits, read/write, reset zero
// - two-bit op_mode_sel picks the operating mode
// - compare mode clears on overflow, A or P
// - clear select low: P match or overflow
// - clear select high: A match, no P flag
// - only comparator A matches move the compare-mode pin
// - pin action: none, low, high or toggle
// - counter_on rise loads pin initial level
// - timer mode counts like compare, pin undriven
// - PWM ignores clear_source_sel entirely
// - period_duty_swap exchanges period and duty comparators
// - P code n gives n*128, zero 1024
// - swapped: period is A, duty P*128
// - duty at or above period gives 100%
// - PWM raises both match flags
// - PWM polarity, force levels and inversion
// - forced pin still keeps PWM counting going
// - on rise zeros counter, fall holds it
// - P compares counter bits 9 to 7
// - pause freezes counter, resume continues
// - out_invert inverts pin except timer and capture modes
module stcp_timer (
  input wire logic clk_in,
  input wire logic rst_in,
  input stcp_pkg::stcp_bus_req_t bus_in,
  input wire logic tck_in,
  output logic [stcp_pkg::DATA_W-1:0] rd_data_out,
  output logic pin_out,
  output logic pin_oe_out
);
  import stcp_pkg::*;

  stcp_state_t st;
  stcp_state_t next_st;
  logic tick;
  logic on;
  logic pause;
  logic on_rise;
  logic step;
  logic [1:0] op_mode;
  logic [1:0] pin_act;
  logic init_lvl;
  logic invert;
  logic swap;
  logic clr_src;
  logic [2:0] cmpp;
  logic [CNT_W:0] cnt_inc;
  logic [CNT_W-1:0] cnt_nxt;
  logic hit_a;
  logic hit_p;
  logic is_pwm;
  logic clear_on_a;
  logic [CNT_W:0] duty;
  logic pwm_active;
  logic pwm_lvl;

  stcp_prescale u_prescale (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clk_sel_in(st.ctrl0[CKSEL_LSB +: 3]),
    .tck_in(tck_in),
    .tick_out(tick)
  );

  function automatic logic [DATA_W-1:0] reg_read(input stcp_state_t s,
                                                  input logic [ADDR_W-1:0] a);
    unique case (a)
      ADDR_CTRL0: reg_read = s.ctrl0;
      ADDR_MODE: reg_read = s.mode;
      ADDR_CNT_LO: reg_read = s.cnt[7:0];
      ADDR_CNT_HI: reg_read = {6'h00, s.cnt[9:8]};
      ADDR_CMPA_LO: reg_read = s.cmpa[7:0];
      ADDR_CMPA_HI: reg_read = {6'h00, s.cmpa[9:8]};
      ADDR_FLAGS: reg_read = {6'h00, s.flag_p, s.flag_a};
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // field views of the control registers
  assign on = st.ctrl0[ON_BIT];
  assign pause = st.ctrl0[PAUSE_BIT];
  assign cmpp = st.ctrl0[CMPP_LSB +: 3];
  assign op_mode = st.mode[OPMODE_LSB +: 2];
  assign pin_act = st.mode[PINACT_LSB +: 2];
  assign init_lvl = st.mode[INIT_BIT];
  assign invert = st.mode[INV_BIT];
  assign swap = st.mode[SWAP_BIT];
  assign clr_src = st.mode[CLRSRC_BIT];

  assign on_rise = on & ~st.on_prev;
  // a rising counter_on wins over a tick in the same cycle
  assign step = on & ~pause & tick & ~on_rise;
  assign cnt_inc = {1'b0, st.cnt} + 11'h001;
  assign cnt_nxt = cnt_inc[CNT_W-1:0];
  assign hit_a = cnt_nxt == st.cmpa;
  // P matches at multiples of 128; code zero matches on the wrap (overflow)
  assign hit_p = (cnt_nxt[9:P_SHIFT] == cmpp) && (cnt_nxt[P_SHIFT-1:0] == 7'h00);
  assign is_pwm = op_mode == MODE_PWM;
  // PWM takes the period comparator from swap only; other modes from clr_src
  assign clear_on_a = is_pwm ? swap : clr_src;
  // swapped duty is the coarse P value, code zero standing for 1024
  assign duty = swap ? ((cmpp == 3'h0) ? P_FULL : {1'b0, cmpp, 7'h00})
                     : {1'b0, st.cmpa};

  always_comb begin
    next_st = st;
    next_st.rd_data = 8'h00;
    next_st.on_prev = on;
    pwm_active = 1'b0;
    pwm_lvl = 1'b0;

    // register writes; flag clears come first so that a match set wins
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        ADDR_CTRL0: next_st.ctrl0 = bus_in.wdata;
        ADDR_MODE: next_st.mode = bus_in.wdata;
        ADDR_CMPA_LO: next_st.cmpa[7:0] = bus_in.wdata;
        ADDR_CMPA_HI: next_st.cmpa[9:8] = bus_in.wdata[1:0];
        ADDR_FLAGS: begin
          next_st.flag_a = st.flag_a & ~bus_in.wdata[FLAG_A_BIT];
          next_st.flag_p = st.flag_p & ~bus_in.wdata[FLAG_P_BIT];
        end
        default: ;
      endcase
    end
    if (bus_in.rd) begin
      next_st.rd_data = reg_read(st, bus_in.addr);
    end

    if (on_rise) begin
      next_st.cnt = '0;
      next_st.pin_lvl = init_lvl;
    end else if (step) begin
      // counting, clearing and flags go on whatever the pin does
      next_st.cnt = (clear_on_a ? hit_a : hit_p) ? '0 : cnt_nxt;
      if (hit_a) begin
        next_st.flag_a = 1'b1;
      end
      if (hit_p && (is_pwm || !clr_src)) begin
        next_st.flag_p = 1'b1;
      end
      // only an A match moves the compare-mode pin
      if (hit_a && !is_pwm) begin
        unique case (pin_act)
          ACT_NONE: next_st.pin_lvl = st.pin_lvl;
          ACT_LOW: next_st.pin_lvl = 1'b0;
          ACT_HIGH: next_st.pin_lvl = 1'b1;
          ACT_TOGGLE: next_st.pin_lvl = ~st.pin_lvl;
        endcase
      end
    end

    // active while the counter sits below duty; duty >= period never drops
    pwm_active = {1'b0, next_st.cnt} < duty;
    unique case (pin_act)
      PWM_FORCE_OFF: pwm_lvl = ~init_lvl;
      PWM_FORCE_ON: pwm_lvl = init_lvl;
      PWM_RUN: pwm_lvl = pwm_active ? init_lvl : ~init_lvl;
      default: pwm_lvl = ~init_lvl;
    endcase

    // timer and capture codes release the pin for other use
    unique case (op_mode)
      MODE_COMPARE: begin
        next_st.pin_oe = 1'b1;
        next_st.pin = next_st.pin_lvl ^ invert;
      end
      MODE_PWM: begin
        next_st.pin_oe = 1'b1;
        next_st.pin = pwm_lvl ^ invert;
      end
      MODE_CAPTURE, MODE_TIMER: begin
        next_st.pin_oe = 1'b0;
        next_st.pin = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '{ctrl0: CTRL0_RST, mode: MODE_RST, cmpa: CMPA_RST, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_out = st.rd_data;
  assign pin_out = st.pin;
  assign pin_oe_out = st.pin_oe;

  property p_cnt_hi_read;
    @(posedge clk_in) disable iff (rst_in)
    (bus_in.rd && bus_in.addr == ADDR_CNT_HI)
      |=> (rd_data_out[7:2] == 6'h00) && (rd_data_out[1:0] == $past(st.cnt[9:8]));
  endproperty
  a_cnt_hi_read: assert property (p_cnt_hi_read) else $error("counter high read wrong");

  property p_cmpa_write;
    @(posedge clk_in) disable iff (rst_in)
    (bus_in.wr && bus_in.addr == ADDR_CMPA_LO) ##1 (bus_in.rd && bus_in.addr == ADDR_CMPA_LO)
      |=> rd_data_out == $past(bus_in.wdata, 2);
  endproperty
  a_cmpa_write: assert property (p_cmpa_write) else $error("compare A readback wrong");

  property p_on_rise_zero;
    @(posedge clk_in) disable iff (rst_in)
    on_rise |=> (st.cnt == 10'h000) ##1 (st.cnt <= 10'h001);
  endproperty
  a_on_rise_zero: assert property (p_on_rise_zero) else $error("counter not zeroed on start");

  property p_pause_hold;
    @(posedge clk_in) disable iff (rst_in)
    (pause && st.on_prev) [*2] |-> $stable(st.cnt);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("counter moved while paused");

  property p_clear_on_a;
    @(posedge clk_in) disable iff (rst_in)
    (step && clear_on_a && hit_a) |=> (st.cnt == 10'h000) && st.flag_a;
  endproperty
  a_clear_on_a: assert property (p_clear_on_a) else $error("A match did not clear");

  property p_no_p_flag;
    @(posedge clk_in) disable iff (rst_in)
    (!is_pwm && clr_src && !st.flag_p) |=> !st.flag_p;
  endproperty
  a_no_p_flag: assert property (p_no_p_flag) else $error("P flag raised with A clear");

  property p_p_period;
    @(posedge clk_in) disable iff (rst_in)
    (step && !clear_on_a && hit_p) |=> (st.cnt == 10'h000) && st.flag_p;
  endproperty
  a_p_period: assert property (p_p_period) else $error("P match did not clear");

  property p_timer_pin;
    @(posedge clk_in) disable iff (rst_in)
    (op_mode == MODE_TIMER) |=> !pin_oe_out;
  endproperty
  a_timer_pin: assert property (p_timer_pin) else $error("pin driven in timer mode");

  property p_pwm_force;
    @(posedge clk_in) disable iff (rst_in)
    (is_pwm && pin_act == PWM_FORCE_ON) |=> pin_oe_out && (pin_out == ($past(init_lvl) ^ $past(invert)));
  endproperty
  a_pwm_force: assert property (p_pwm_force) else $error("forced PWM level wrong");

  property p_pin_init;
    @(posedge clk_in) disable iff (rst_in)
    (on_rise && op_mode == MODE_COMPARE) |=> pin_out == ($past(init_lvl) ^ $past(invert));
  endproperty
  a_pin_init: assert property (p_pin_init) else $error("pin not at initial level");

  property p_cnt_lo_read;
    @(posedge clk_in) disable iff (rst_in)
    (bus_in.rd && bus_in.addr == ADDR_CNT_LO) |=> rd_data_out == $past(st.cnt[7:0]);
  endproperty
  a_cnt_lo_read: assert property (p_cnt_lo_read) else $error("counter low read wrong");

  property p_cmpa_hi_read;
    @(posedge clk_in) disable iff (rst_in)
    (bus_in.rd && bus_in.addr == ADDR_CMPA_HI)
      |=> rd_data_out == {6'h00, $past(st.cmpa[9:8])};
  endproperty
  a_cmpa_hi_read: assert property (p_cmpa_hi_read) else $error("compare A high read wrong");

  property p_rd_idle;
    @(posedge clk_in) disable iff (rst_in)
    !bus_in.rd |=> rd_data_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

  property p_count_step;
    @(posedge clk_in) disable iff (rst_in)
    (step && !(clear_on_a ? hit_a : hit_p))
      |=> st.cnt == $past(st.cnt) + 10'h001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step by one");

  property p_off_hold;
    @(posedge clk_in) disable iff (rst_in)
    !on |=> $stable(st.cnt);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("counter moved while off");

  property p_pin_still;
    @(posedge clk_in) disable iff (rst_in)
    (op_mode == MODE_COMPARE && $stable(st.mode) && !on_rise && !(step && hit_a))
      |=> $stable(pin_out);
  endproperty
  a_pin_still: assert property (p_pin_still) else $error("pin moved without A match");

  property p_pin_toggle;
    @(posedge clk_in) disable iff (rst_in)
    (op_mode == MODE_COMPARE && $stable(st.mode) && step && hit_a && pin_act == ACT_TOGGLE)
      |=> pin_out != $past(pin_out);
  endproperty
  a_pin_toggle: assert property (p_pin_toggle) else $error("pin did not toggle");

  property p_pin_high;
    @(posedge clk_in) disable iff (rst_in)
    (op_mode == MODE_COMPARE && step && hit_a && pin_act == ACT_HIGH)
      |=> pin_out == ~$past(invert);
  endproperty
  a_pin_high: assert property (p_pin_high) else $error("pin not driven high");

  property p_pin_low;
    @(posedge clk_in) disable iff (rst_in)
    (op_mode == MODE_COMPARE && step && hit_a && pin_act == ACT_LOW)
      |=> pin_out == $past(invert);
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin not driven low");

  property p_pwm_run;
    @(posedge clk_in) disable iff (rst_in)
    (is_pwm && pin_act == PWM_RUN)
      |=> pin_out == ((({1'b0, st.cnt} < $past(duty)) ? $past(init_lvl) : ~$past(init_lvl))
                      ^ $past(invert));
  endproperty
  a_pwm_run: assert property (p_pwm_run) else $error("pwm level wrong");

  property p_pwm_force_off;
    @(posedge clk_in) disable iff (rst_in)
    (is_pwm && pin_act == PWM_FORCE_OFF)
      |=> pin_oe_out && (pin_out == ~($past(init_lvl) ^ $past(invert)));
  endproperty
  a_pwm_force_off: assert property (p_pwm_force_off) else $error("forced off level wrong");

  property p_a_flag;
    @(posedge clk_in) disable iff (rst_in)
    (step && hit_a) |=> st.flag_a;
  endproperty
  a_a_flag: assert property (p_a_flag) else $error("A match flag not raised");

  property p_full_duty;
    @(posedge clk_in) disable iff (rst_in)
    (is_pwm && pin_act == PWM_RUN && !swap && cmpp != 3'h0 && st.cmpa >= {cmpp, 7'h00}
      && st.cnt < {cmpp, 7'h00}) |=> pin_out == ($past(init_lvl) ^ $past(invert));
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty not held active");

  property p_pwm_oe;
    @(posedge clk_in) disable iff (rst_in)
    (is_pwm || op_mode == MODE_COMPARE) |=> pin_oe_out;
  endproperty
  a_pwm_oe: assert property (p_pwm_oe) else $error("pin not driven");

endmodule : stcp_timer

// ==== stcp_load.sv ====
// Purpose: load on the timer output pin, measures the runs of each level
// Assumes: pin sampled on clk_in, only while the block drives it
// Notes: a released pin is not measured, a pull-up would hide its level
`timescale 1ns/1ps
module stcp_load (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  input wire logic oe_in,
  output int hi_len_out,
  output int lo_len_out,
  output int edges_out
);
  logic last;
  int run;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      last <= 1'b0;
      run <= 0;
      hi_len_out <= 0;
      lo_len_out <= 0;
      edges_out <= 0;
    end else if (oe_in) begin
      if (pin_in !== last) begin
        if (last) hi_len_out <= run;
        else lo_len_out <= run;
        run <= 1;
        edges_out <= edges_out + 1;
      end else begin
        run <= run + 1;
      end
      last <= pin_in;
    end
  end
endmodule : stcp_load

// ==== stcp_timer_bench.sv ====
// Purpose: self-checking bench of the 10-bit standard timer
// Assumes: timer clock select 001, one tick per clk_in
// Notes: external clock pin held low, prescaler paths other than 001 unused
`timescale 1ns/1ps
module stcp_timer_bench;
  import stcp_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  stcp_bus_req_t bus = '0;
  logic [7:0] rd_data;
  logic pin;
  logic pin_oe;
  int hi_len;
  int lo_len;
  int edges;
  int num_errors = 0;
  int checks = 0;
  logic [7:0] d;
  logic [7:0] d2;
  logic [7:0] m;
  logic [7:0] c;
  logic [9:0] a;
  logic [15:0] h;
  logic [15:0] l;
  logic x;
  int e;
  // addr, write data, read back
  localparam logic [18:0] REGS [6] = '{{ADDR_CMPA_LO, 8'hA5, 8'hA5},
    {ADDR_CMPA_HI, 8'hFF, 8'h03}, {ADDR_CNT_LO, 8'h5A, 8'h00},
    {ADDR_CNT_HI, 8'hFF, 8'h00}, {3'h7, 8'hFF, 8'h00}, {ADDR_MODE, 8'hC0, 8'hC0}};
  // compare mode byte, pin level after a match
  localparam logic [8:0] ACTS [4] = '{{8'h19, 1'b0}, {8'h21, 1'b1},
    {8'h09, 1'b1}, {8'h0D, 1'b0}};
  // pwm mode, compare A, ctrl0, high run, low run
  localparam logic [57:0] PWMS [6] = '{
    {8'hA8, 10'h020, 8'h11, 16'h0020, 16'h0060},
    {8'hAC, 10'h020, 8'h11, 16'h0060, 16'h0020},
    {8'hAA, 10'h12C, 8'h11, 16'h0080, 16'h00AC},
    {8'hA9, 10'h020, 8'h11, 16'h0020, 16'h0060},
    {8'hA8, 10'h020, 8'h13, 16'h0020, 16'h0160},
    {8'hA0, 10'h020, 8'h11, 16'h0060, 16'h0020}};

  always #5 clk_in = ~clk_in;

  stcp_timer u_dut (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus), .tck_in(1'b0),
    .rd_data_out(rd_data), .pin_out(pin), .pin_oe_out(pin_oe));
  stcp_load u_load (.clk_in(clk_in), .rst_in(rst_in), .pin_in(pin), .oe_in(pin_oe),
    .hi_len_out(hi_len), .lo_len_out(lo_len), .edges_out(edges));

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", n, x, s);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  task automatic wr(input logic [2:0] ad, input logic [7:0] wd);
    @(posedge clk_in);
    bus.wr <= 1'b1;
    bus.addr <= ad;
    bus.wdata <= wd;
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] ad, output logic [7:0] q);
    @(posedge clk_in);
    bus.rd <= 1'b1;
    bus.addr <= ad;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 q = rd_data;
  endtask : rd

  // timer is stopped around every mode change
  task automatic run(input logic [7:0] mo, input logic [9:0] ca, input logic [7:0] c0);
    wr(ADDR_CTRL0, c0);
    wr(ADDR_MODE, mo);
    wr(ADDR_CMPA_LO, ca[7:0]);
    wr(ADDR_CMPA_HI, {6'h00, ca[9:8]});
    wr(ADDR_FLAGS, 8'h03);
    wr(ADDR_CTRL0, c0 | 8'h08);
  endtask : run

  task automatic final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (60000) @(posedge clk_in);
    num_errors++;
    final_report();
  end

  initial begin
    cyc(12);
    rst_in <= 1'b0;
    check("pin_oe reset", {31'h0, pin_oe}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      rd(i[2:0], d);
      check("reset value", {24'h0, d}, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      wr(REGS[i][18:16], REGS[i][15:8]);
      rd(REGS[i][18:16], d);
      check("register", {24'h0, d}, {24'h0, REGS[i][7:0]});
    end
    // write then read with no gap between the strobes
    @(posedge clk_in);
    bus.wr <= 1'b1;
    bus.addr <= ADDR_CMPA_LO;
    bus.wdata <= 8'h3C;
    @(posedge clk_in);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 d = rd_data;
    check("write then read", {24'h0, d}, 32'h3C);
    for (int i = 0; i < 4; i++) begin
      {m, x} = ACTS[i];
      run(m, 10'h064, 8'h11);
      cyc(150);
      check("match pin", {31'h0, pin}, {31'h0, x});
    end
    for (int i = 0; i < 6; i++) begin
      {m, a, c, h, l} = PWMS[i];
      run(m, a, c);
      cyc(1300);
      check("pwm high", hi_len, {16'h0, h});
      check("pwm low", lo_len, {16'h0, l});
    end
    // clear by A with P below A: period is A, no P flag
    run(8'h31, 10'h0C8, 8'h11);
    cyc(700);
    check("oe compare", {31'h0, pin_oe}, 32'h1);
    check("toggle gap", hi_len, 32'hC8);
    check("toggle gap", lo_len, 32'hC8);
    rd(ADDR_FLAGS, d);
    check("flags a", {24'h0, d & 8'h03}, 32'h1);
    // clear by P, A match inside the period
    run(8'h30, 10'h064, 8'h11);
    cyc(500);
    check("p period", hi_len, 32'h80);
    rd(ADDR_FLAGS, d);
    check("flags ap", {24'h0, d & 8'h03}, 32'h3);
    wr(ADDR_CTRL0, 8'h99);
    rd(ADDR_CNT_LO, d);
    cyc(20);
    rd(ADDR_CNT_LO, d2);
    check("paused count", {24'h0, d2}, {24'h0, d});
    wr(ADDR_CTRL0, 8'h19);
    cyc(20);
    rd(ADDR_CNT_LO, d2);
    check("resumed count", {31'h0, d2 != d}, 32'h1);
    // P code zero clears on overflow
    run(8'h30, 10'h064, 8'h10);
    cyc(2200);
    check("overflow gap", lo_len, 32'h400);
    wr(ADDR_CTRL0, 8'h98);
    rd(ADDR_CNT_HI, d);
    check("count high pad", {24'h0, d & 8'hFC}, 32'h0);
    // initial level on each start, counter held while off
    run(8'h39, 10'h064, 8'h11);
    cyc(3);
    check("init level", {31'h0, pin}, 32'h1);
    cyc(100);
    check("toggled", {31'h0, pin}, 32'h0);
    wr(ADDR_CTRL0, 8'h11);
    rd(ADDR_CNT_LO, d);
    cyc(30);
    rd(ADDR_CNT_LO, d2);
    check("held count", {24'h0, d2}, {24'h0, d});
    wr(ADDR_CTRL0, 8'h19);
    cyc(3);
    check("init again", {31'h0, pin}, 32'h1);
    // duty above period stays fully active
    run(8'hA8, 10'h0C8, 8'h11);
    cyc(300);
    e = edges;
    cyc(400);
    check("full duty edges", edges, e);
    check("full duty pin", {31'h0, pin}, 32'h1);
    rd(ADDR_FLAGS, d);
    // counter wraps at 128 before reaching A, so only P matches
    check("pwm flags", {24'h0, d & 8'h03}, 32'h2);
    // forced levels, counting goes on
    run(8'h88, 10'h020, 8'h11);
    cyc(400);
    check("force off", {31'h0, pin}, 32'h0);
    rd(ADDR_FLAGS, d);
    check("forced flags", {24'h0, d & 8'h03}, 32'h3);
    run(8'h98, 10'h020, 8'h11);
    cyc(400);
    check("force on", {31'h0, pin}, 32'h1);
    // timer mode leaves the pin alone
    run(8'hF1, 10'h064, 8'h11);
    cyc(300);
    check("timer oe", {31'h0, pin_oe}, 32'h0);
    rd(ADDR_FLAGS, d);
    check("timer flags", {24'h0, d & 8'h03}, 32'h1);
    final_report();
  end
endmodule : stcp_timer_bench
